// file: design/uob_pkg.sv
/*
 package for the oversampling, break and lin receive/transmit block.
 assumes one 200 mhz clock and a synchronous active-low reset.
*/
package uob_pkg;
   localparam int       DATA_W       = 8;
   localparam int       FIFO_DEPTH   = 8;
   localparam logic [3:0] OSR_MIN    = 4'h4;   // ratio minus one, 5x
   localparam logic [3:0] OSR_MAX    = 4'hf;   // ratio minus one, 16x
   localparam logic [3:0] OSR_RST    = 4'hf;
   localparam logic [4:0] BRK_STD    = 5'h10;  // 16 bit times
   localparam logic [4:0] BRK_LIN    = 5'h0b;  // 11 bit times
   localparam logic [4:0] TXBRK_LIN  = 5'h0d;  // 13 bit times
   localparam logic [3:0] CHAR_BITS  = 4'ha;   // start, 8 data, stop
   localparam logic [4:0] AB_TMO_BITS = 5'h1f; // auto-baud timeout in 32768-clock units
   localparam logic [15:0] DIV_MAX   = 16'hffff;

   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_AB} uob_rx_st_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_LBRK} uob_tx_st_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              frame_err;
      logic              brk;
   } uob_rx_word_t;

   typedef struct packed {
      logic       lin_mode;
      logic       sync_mode;
      logic       tx_disable_ctrl;
      logic       tx_break_enable;
      logic       autobaud_en;
      logic [3:0] oversample_select_reg;
      logic [15:0] baud_divider;
   } uob_ctrl_t;
endpackage

// file: design/uob_fifo.sv
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes single clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module uob_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } uob_fifo_st_t;
   uob_fifo_st_t s_r, s_nxt;
   logic push, pop;

   // honest full and empty from the count
   assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointer and storage update
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // uob_fifo

// file: design/uob_core.sv
/*
 oversampled async receiver/transmitter core with break and lin handling.
 assumes rxd is already synchronous to clk; received words pass a fifo.
*/
`timescale 1ns/100ps
module uob_core (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire uob_pkg::uob_ctrl_t  ctrl,
   input  wire logic                tx_valid,
   input  wire logic [7:0]          tx_data,
   input  wire logic                rxd,
   input  wire logic                break_flag_clr,
   input  wire logic                ab_err_clr,
   input  wire logic                wake_en_start,
   input  wire logic                rx_ready,
   output logic                     tx_ready,
   output logic                     txd,
   output logic [7:0]               rx_char_value,
   output logic                     rx_frame_err,
   output logic                     rx_break_char,
   output logic                     rx_valid,
   output logic                     rx_break_change_flag,
   output logic                     rx_break_active,
   output logic                     tx_disabled_status,
   output logic                     autobaud_timeout_error,
   output logic                     autobaud_done,
   output logic [15:0]              baud_divider_load,
   output logic                     wake_req
);
   typedef struct packed {
      logic [15:0]         div_cnt;
      logic [3:0]          rx_os;
      logic [3:0]          tx_os;
      uob_pkg::uob_rx_st_t rx_st;
      logic [3:0]          rx_bit;
      logic [7:0]          rx_sh;
      logic [1:0]          maj;
      logic [4:0]          low_bits;
      logic                brk_on;
      uob_pkg::uob_tx_st_t tx_st;
      logic [3:0]          tx_bit;
      logic [9:0]          tx_sh;
      logic [4:0]          lbrk_bits;
      logic                txd;
      logic                wr_valid;
      uob_pkg::uob_rx_word_t wr_word;
      logic                brk_flag;
      logic                dis_stat;
      logic                ab_err;
      logic                ab_done;
      logic [15:0]         ab_div;
      logic [19:0]         ab_cnt;
      logic                ab_seen_low;
      logic                ab_prev;
      logic                wake;
   } uob_st_t;
   uob_st_t s_r, s_nxt;

   logic tick, rx_bit_end, tx_bit_end, samp, rx_bit_val, brk_lim;
   logic brk_set, stop_done, stop_val;
   logic wr_ready;
   logic [3:0]  ratio_m1;
   logic [3:0]  mid;
   logic [4:0]  brk_len;
   logic [9:0]  fifo_out;

   // divided clock enable and per-bit ratio
   assign tick     = (s_r.div_cnt == '0);
   assign ratio_m1 = ctrl.sync_mode ? 4'h0 :
                     (ctrl.oversample_select_reg < uob_pkg::OSR_MIN) ? uob_pkg::OSR_MIN
                     : ctrl.oversample_select_reg;
   assign mid        = ratio_m1 >> 1;
   assign samp       = tick & ((s_r.rx_os == mid - 4'h1) | (s_r.rx_os == mid)
                       | (s_r.rx_os == mid + 4'h1) | ctrl.sync_mode);
   assign rx_bit_end = tick & (s_r.rx_os == ratio_m1);
   assign tx_bit_end = tick & (s_r.tx_os == ratio_m1);
   assign rx_bit_val = ctrl.sync_mode ? rxd : s_r.maj[1];
   assign brk_len    = ctrl.lin_mode ? uob_pkg::BRK_LIN : uob_pkg::BRK_STD;
   assign brk_lim    = (s_r.low_bits == brk_len);
   // end-of-break event, so a clear in the same cycle loses to it
   assign brk_set    = rx_bit_end & rxd & s_r.brk_on;
   // oversampled stop bit is judged at its third sample, not at its end; sync mode judges it at its end
   assign stop_done  = ctrl.sync_mode ? rx_bit_end : tick & (s_r.rx_os == mid + 4'h1);
   assign stop_val   = ctrl.sync_mode ? rxd : (s_r.maj[1] | (s_r.maj[0] & rxd));

   // next state of the whole core
   always_comb begin
      s_nxt = s_r;
      s_nxt.wr_valid = s_r.wr_valid & ~wr_ready;
      s_nxt.wake = 1'b0;
      s_nxt.ab_done = 1'b0;
      s_nxt.div_cnt = tick ? ctrl.baud_divider : s_r.div_cnt - 16'h1;
      if (tick) begin
         s_nxt.rx_os = (s_r.rx_os == ratio_m1) ? 4'h0 : s_r.rx_os + 4'h1;
         s_nxt.tx_os = (s_r.tx_os == ratio_m1) ? 4'h0 : s_r.tx_os + 4'h1;
      end
      // majority count over three samples
      if (samp) begin
         s_nxt.maj = s_r.maj + {1'b0, rxd};
      end
      // break detector runs independent of character state
      if (rx_bit_end) begin
         if (rxd) begin
            s_nxt.low_bits = '0;
            if (s_r.brk_on) begin
               s_nxt.brk_on = 1'b0;
               s_nxt.brk_flag = 1'b1;
            end
         end else if (!brk_lim) begin
            s_nxt.low_bits = s_r.low_bits + 5'h1;
         end
      end
      if (brk_lim & ~s_r.brk_on) begin
         s_nxt.brk_on = 1'b1;
         s_nxt.brk_flag = 1'b1;
         s_nxt.wr_valid = 1'b1;
         s_nxt.wr_word = '{data: 8'h00, frame_err: 1'b1, brk: 1'b1};
         s_nxt.rx_st = uob_pkg::RX_IDLE;
      end else if (break_flag_clr & ~brk_set) begin
         s_nxt.brk_flag = 1'b0;
      end
      // receiver character machine
      unique case (s_r.rx_st)
         uob_pkg::RX_IDLE: begin
            if (!rxd & !s_r.brk_on) begin
               s_nxt.rx_st = ctrl.autobaud_en ? uob_pkg::RX_AB : uob_pkg::RX_DATA;
               s_nxt.rx_os = 4'h0;
               s_nxt.rx_bit = 4'h0;
               s_nxt.maj = '0;
               s_nxt.wake = wake_en_start;
               s_nxt.ab_cnt = '0;
               s_nxt.ab_seen_low = 1'b1;
            end
         end
         uob_pkg::RX_DATA: begin
            if (s_r.rx_bit == CHAR_BITS_M1()) begin
               // leave mid-stop so back-to-back frames keep alignment
               if (stop_done) begin
                  s_nxt.maj = '0;
                  s_nxt.rx_st = uob_pkg::RX_IDLE;
                  s_nxt.wr_valid = ~s_r.brk_on;
                  s_nxt.wr_word = '{data: s_r.rx_sh, frame_err: ~stop_val, brk: 1'b0};
                  s_nxt.ab_done = s_r.ab_seen_low & ctrl.autobaud_en;
               end
            end else if (rx_bit_end) begin
               s_nxt.maj = '0;
               s_nxt.rx_bit = s_r.rx_bit + 4'h1;
               if (s_r.rx_bit == 4'h0 && rx_bit_val) begin
                  s_nxt.rx_st = uob_pkg::RX_IDLE;                  // false start
               end else if (s_r.rx_bit != 4'h0) begin
                  s_nxt.rx_sh = {rx_bit_val, s_r.rx_sh[7:1]};
               end
            end
         end
         uob_pkg::RX_AB: begin
            // measure start bit in function clocks; divider counter zeroed when it ends
            s_nxt.ab_cnt = s_r.ab_cnt + 20'h1;
            if (rxd) begin
               s_nxt.ab_div = 16'((s_r.ab_cnt + 20'(ratio_m1 >> 1))
                              / 20'({1'b0, ratio_m1} + 5'h1) - 20'h1);
               s_nxt.rx_st = uob_pkg::RX_DATA;
               s_nxt.rx_bit = 4'h1;
               s_nxt.rx_os = 4'h0;
               s_nxt.maj = '0;
               s_nxt.div_cnt = '0;
            end else if (s_r.ab_cnt[19 -: 5] == uob_pkg::AB_TMO_BITS) begin
               s_nxt.ab_err = 1'b1;
               s_nxt.rx_st = uob_pkg::RX_IDLE;
            end
         end
         default: s_nxt.rx_st = uob_pkg::RX_IDLE;
      endcase
      if (ab_err_clr & ~(s_nxt.ab_err & ~s_r.ab_err)) begin
         s_nxt.ab_err = 1'b0;
      end
      // transmitter
      unique case (s_r.tx_st)
         uob_pkg::TX_IDLE: begin
            s_nxt.dis_stat = ctrl.tx_disable_ctrl;
            if (tx_valid & ~ctrl.tx_disable_ctrl) begin
               s_nxt.tx_os = 4'h0;
               s_nxt.tx_bit = 4'h0;
               if (ctrl.lin_mode & ctrl.tx_break_enable) begin
                  s_nxt.tx_st = uob_pkg::TX_LBRK;
                  s_nxt.lbrk_bits = '0;
               end else begin
                  s_nxt.tx_st = uob_pkg::TX_SHIFT;
                  s_nxt.tx_sh = {1'b1, tx_data, 1'b0};
               end
            end
         end
         uob_pkg::TX_SHIFT: begin
            s_nxt.dis_stat = 1'b0;
            if (tx_bit_end) begin
               s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
               s_nxt.tx_bit = s_r.tx_bit + 4'h1;
               if (s_r.tx_bit == CHAR_BITS_M1()) s_nxt.tx_st = uob_pkg::TX_IDLE;
            end
         end
         uob_pkg::TX_LBRK: begin
            if (tx_bit_end) begin
               s_nxt.lbrk_bits = s_r.lbrk_bits + 5'h1;
               if (s_r.lbrk_bits == uob_pkg::TXBRK_LIN - 5'h1) begin
                  s_nxt.tx_st = uob_pkg::TX_IDLE;
               end
            end
         end
         default: s_nxt.tx_st = uob_pkg::TX_IDLE;
      endcase
      // standard break overrides any activity
      s_nxt.txd = (s_nxt.tx_st == uob_pkg::TX_LBRK) ? 1'b0 :
                  (ctrl.tx_break_enable & ~ctrl.lin_mode) ? 1'b0 :
                  (s_nxt.tx_st == uob_pkg::TX_SHIFT) ? s_nxt.tx_sh[0] : 1'b1;
   end

   function automatic logic [3:0] CHAR_BITS_M1();
      return uob_pkg::CHAR_BITS - 4'h1;
   endfunction

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.txd <= 1'b1;
         s_r.ab_prev <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // received words through the fifo
   uob_fifo #(.WIDTH(10), .DEPTH(uob_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   (s_r.wr_word),
      .in_valid  (s_r.wr_valid),
      .in_ready  (wr_ready),
      .out_data  (fifo_out),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   assign rx_char_value          = fifo_out[9:2];
   assign rx_frame_err           = fifo_out[1];
   assign rx_break_char          = fifo_out[0];
   assign tx_ready               = (s_r.tx_st == uob_pkg::TX_IDLE) & ~ctrl.tx_disable_ctrl;
   assign txd                    = s_r.txd;
   assign rx_break_change_flag   = s_r.brk_flag;
   assign rx_break_active        = s_r.brk_on;
   assign tx_disabled_status     = s_r.dis_stat;
   assign autobaud_timeout_error = s_r.ab_err;
   assign autobaud_done          = s_r.ab_done;
   assign baud_divider_load      = s_r.ab_div;
   assign wake_req               = s_r.wake;
endmodule // uob_core

// file: bench/uob_core_chk.sv
/*
 port checker for uob_core: break, transmit and flag timing.
 bound from the bench top; one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module uob_core_chk (
   input wire logic               clk,
   input wire logic               nrst,
   input wire uob_pkg::uob_ctrl_t ctrl,
   input wire logic               tx_valid,
   input wire logic               tx_ready,
   input wire logic               txd,
   input wire logic               rxd,
   input wire logic               break_flag_clr,
   input wire logic               wake_en_start,
   input wire logic               wake_req,
   input wire logic [7:0]         rx_char_value,
   input wire logic               rx_frame_err,
   input wire logic               rx_break_char,
   input wire logic               rx_valid,
   input wire logic               rx_break_change_flag,
   input wire logic               rx_break_active,
   input wire logic               tx_disabled_status
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   int lo_cnt_r;
   int bit_clks;
   // clocks per bit, and length of the current low run on rxd
   assign bit_clks = (int'(ctrl.oversample_select_reg) + 1) * (int'(ctrl.baud_divider) + 1);
   always_ff @(posedge clk) lo_cnt_r <= rxd ? 0 : lo_cnt_r + 1;
   // standard break request held over two edges
   sequence s_std_brk;
      (ctrl.tx_break_enable && !ctrl.lin_mode) [*2];
   endsequence
   sequence s_take;
      tx_valid && tx_ready;
   endsequence
   brk_hold_a: assert property (s_std_brk |-> !txd)
      else $error("txd high while break held");
   tx_start_a: assert property (s_take |=> !txd)
      else $error("no start bit after taken char");
   tx_refuse_a: assert property (ctrl.tx_disable_ctrl |-> !tx_ready)
      else $error("char accepted while disabled");
   dis_rise_a: assert property ($rose(tx_disabled_status) |-> $past(ctrl.tx_disable_ctrl) && txd)
      else $error("disabled status rose too early");
   brk_flag_a: assert property ($changed(rx_break_active) |-> ##[0:2] rx_break_change_flag)
      else $error("break change not flagged");
   flag_keep_a: assert property (rx_break_change_flag && !break_flag_clr |=> rx_break_change_flag)
      else $error("break flag lost");
   brk_len_a: assert property ($rose(rx_break_active) |->
      lo_cnt_r >= (ctrl.lin_mode ? 10 : 15) * bit_clks && lo_cnt_r <= (ctrl.lin_mode ? 13 : 18) * bit_clks)
      else $error("break declared at wrong length");
   brk_word_a: assert property (rx_valid && rx_break_char |-> rx_frame_err && rx_char_value == 8'h00)
      else $error("break word malformed");
   wake_a: assert property (wake_req |-> $past(wake_en_start) ##1 !wake_req)
      else $error("bad wake pulse");
endmodule // uob_core_chk

// file: bench/uob_node.sv
/*
 behavioural remote serial node: drives rxd, measures txd.
 assumes the bench sets bc to clocks per bit and calls tasks at rising edges.
*/
`timescale 1ns/100ps
module uob_node (
   input wire logic clk,
   input wire logic txd,
   output logic     rxd
);
   int bc = 5;
   // line rests at the mark level
   initial rxd = 1'b1;
   // one frame: start, eight data lsb first, stop
   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (bc) @(posedge clk);
      end
   endtask
   // hold the line low for a number of bit times
   task automatic hold_low(input int nb);
      rxd <= 1'b0;
      repeat (nb * bc) @(posedge clk);
      rxd <= 1'b1;
   endtask
   // capture a frame from txd at mid-bit
   task automatic rcv(output logic [9:0] f);
      int w = 0;
      f = '0;
      while (txd !== 1'b0 && w < 5000) begin
         @(negedge clk);
         w++;
      end
      repeat (bc / 2) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = txd;
         repeat (bc) @(negedge clk);
      end
   endtask
   // count clocks of the next low stretch on txd
   task automatic low_len(output int n);
      int w = 0;
      n = 0;
      while (txd !== 1'b0 && w < 5000) begin
         @(negedge clk);
         w++;
      end
      while (txd === 1'b0 && n < 5000) begin
         @(negedge clk);
         n++;
      end
   endtask
endmodule // uob_node

// file: bench/uob_core_tb_top.sv
/*
 self-checking bench for uob_core with a serial node model.
 assumes uob_pkg, uob_fifo, uob_core, uob_node and uob_core_chk compiled first.
*/
`timescale 1ns/100ps
module uob_core_tb_top;
   logic               clk = 1'b0;
   logic               nrst = 1'b0;
   uob_pkg::uob_ctrl_t ctrl = '0;
   logic               tx_valid = 1'b0;
   logic [7:0]         tx_data = 8'h00;
   logic               break_flag_clr = 1'b0;
   logic               rx_ready = 1'b0;
   logic               rxd, txd, tx_ready, rx_frame_err, rx_break_char, rx_valid;
   logic               rx_break_change_flag, rx_break_active, tx_disabled_status, wake_req;
   logic [7:0]         rx_char_value;
   logic [3:0]         rat [3] = '{4'h4, 4'h9, 4'hf};
   int                 n_errors = 0;
   int                 n_tests = 0;
   int                 cyc = 0;
   uob_core uob_core_i (.clk(clk), .nrst(nrst), .ctrl(ctrl), .tx_valid(tx_valid),
      .tx_data(tx_data), .rxd(rxd), .break_flag_clr(break_flag_clr), .ab_err_clr(1'b0),
      .wake_en_start(1'b1), .rx_ready(rx_ready), .tx_ready(tx_ready), .txd(txd),
      .rx_char_value(rx_char_value), .rx_frame_err(rx_frame_err), .rx_break_char(rx_break_char),
      .rx_valid(rx_valid), .rx_break_change_flag(rx_break_change_flag),
      .rx_break_active(rx_break_active), .tx_disabled_status(tx_disabled_status),
      .autobaud_timeout_error(), .autobaud_done(), .baud_divider_load(), .wake_req(wake_req));
   uob_node uob_node_i (.clk(clk), .txd(txd), .rxd(rxd));
   // free-running 200 mhz clock
   always #2.5 clk = ~clk;
   // cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] want);
      n_tests++;
      if (got !== want) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, want, got);
      end
   endtask
   // offer one char and hold it until taken
   task automatic put(input logic [7:0] d);
      int n = 0;
      tx_valid <= 1'b1;
      tx_data <= d;
      @(negedge clk);
      while (tx_ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      tx_valid <= 1'b0;
   endtask
   // pop the receive fifo head
   task automatic rd(output uob_pkg::uob_rx_word_t w);
      int n = 0;
      @(negedge clk);
      while (rx_valid !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      w = {rx_char_value, rx_frame_err, rx_break_char};
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
   endtask
   // read all words left by a long low, note any break word
   task automatic drain(output logic brk);
      uob_pkg::uob_rx_word_t w;
      brk = 1'b0;
      repeat (120) @(negedge clk);
      while (rx_valid === 1'b1) begin
         rd(w);
         if (w.brk) chk("low_word", {w.data, w.frame_err}, 16'h0001);
         brk = brk | w.brk;
      end
   endtask
   task automatic ratio(input logic [3:0] m);
      @(posedge clk);
      ctrl.oversample_select_reg <= m;
      uob_node_i.bc = int'(m) + 1;
   endtask
   // main sequence
   initial begin
      logic [9:0] f;
      uob_pkg::uob_rx_word_t w;
      logic b;
      int n;
      ctrl.oversample_select_reg = 4'h4;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         ratio(rat[i]);
         @(posedge clk);
         fork
            uob_node_i.rcv(f);
            put(8'ha5 ^ {4'h0, rat[i]});
         join
         chk("tx_frame", 16'(f), {6'h0, 1'b1, 8'ha5 ^ {4'h0, rat[i]}, 1'b0});
         @(posedge clk);
         uob_node_i.send(8'h3c ^ {rat[i], 4'h0});
         rd(w);
         chk("rx_word", 16'(w), {6'h0, 8'h3c ^ {rat[i], 4'h0}, 2'b00});
      end
      ratio(4'h4);
      for (int k = 0; k < 9; k++) uob_node_i.send(8'h40 + 8'(k));
      for (int k = 0; k < 8; k++) begin
         rd(w);
         chk("fifo_word", 16'(w), {6'h0, 8'h40 + 8'(k), 2'b00});
      end
      repeat (60) @(negedge clk);
      while (rx_valid === 1'b1) rd(w);
      @(posedge clk);
      fork
         uob_node_i.hold_low(20);
         begin
            repeat (92) @(negedge clk);
            chk("flag_start", rx_break_change_flag, 16'h1);
            @(posedge clk);
            break_flag_clr <= 1'b1;
            @(posedge clk);
            break_flag_clr <= 1'b0;
            @(negedge clk);
            chk("flag_clr", rx_break_change_flag, 16'h0);
         end
      join
      repeat (10) @(negedge clk);
      chk("flag_end", rx_break_change_flag, 16'h1);
      drain(b);
      chk("brk_std", b, 16'h1);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         ctrl.lin_mode <= m[0];
         uob_node_i.hold_low(12);
         drain(b);
         chk("brk_12", b, 16'(m));
      end
      @(posedge clk);
      ctrl.lin_mode <= 1'b0;
      ctrl.tx_disable_ctrl <= 1'b1;
      n = 0;
      while (tx_disabled_status !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("tx_dis", tx_disabled_status, 16'h1);
      @(posedge clk);
      ctrl.tx_break_enable <= 1'b1;
      repeat (40) @(negedge clk);
      chk("brk_txd", txd, 16'h0);
      @(posedge clk);
      ctrl.tx_break_enable <= 1'b0;
      repeat (4) @(negedge clk);
      chk("brk_end", txd, 16'h1);
      @(posedge clk);
      ctrl.tx_disable_ctrl <= 1'b0;
      ctrl.lin_mode <= 1'b1;
      ctrl.tx_break_enable <= 1'b1;
      @(posedge clk);
      fork
         uob_node_i.low_len(n);
         put(8'h00);
      join
      chk("lin_brk", 16'(n), 16'd65);
      @(posedge clk);
      ctrl.tx_break_enable <= 1'b0;
      repeat (200) @(posedge clk);
      summarize();
   end
endmodule // uob_core_tb_top
bind uob_core uob_core_chk uob_core_chk_i (.clk(clk), .nrst(nrst), .ctrl(ctrl),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .txd(txd), .rxd(rxd),
   .break_flag_clr(break_flag_clr), .wake_en_start(wake_en_start), .wake_req(wake_req),
   .rx_char_value(rx_char_value), .rx_frame_err(rx_frame_err), .rx_break_char(rx_break_char),
   .rx_valid(rx_valid), .rx_break_change_flag(rx_break_change_flag),
   .rx_break_active(rx_break_active), .tx_disabled_status(tx_disabled_status));
